// ---- src/alc_defines.vh ----
// Constants for the automatic level control block
`ifndef ALC_DEFINES_VH
`define ALC_DEFINES_VH

// Register byte offsets
`define ALC_ADDR_CTRL   8'h00
`define ALC_ADDR_CFG_A  8'h04
`define ALC_ADDR_CFG_B  8'h08
`define ALC_ADDR_VOL_A  8'h0C
`define ALC_ADDR_VOL_B  8'h10
`define ALC_ADDR_STAT   8'h14

// Control register fields
`define ALC_CT_PAIR_A   0
`define ALC_CT_PAIR_B   1
`define ALC_CT_QUAD     2
`define ALC_CT_FAST_LIM 3

// Pair configuration register fields
`define ALC_CF_THR      1:0
`define ALC_CF_GATE_DIS 2
`define ALC_CF_LSTEP    4:3
`define ALC_CF_ZTMO     6:5
`define ALC_CF_WAIT     9:7
`define ALC_CF_GAIN     11:10
`define ALC_CF_FREC     13:12
`define ALC_CF_CEIL     23:16

// Reset values
`define ALC_CFG_RST     32'h00E1_0000
`define ALC_VOL_RST     16'h9191
`define ALC_VOL_CH_RST  8'h91

// Volume codes
`define ALC_VOL_MUTE    8'h00
`define ALC_VOL_ONE     8'h01

// Base sample periods of zero-cross timeout and recovery wait, and base shift of fast recovery
`define ALC_ZTMO_BASE   11'h080
`define ALC_WAIT_BASE   15'h0080
`define ALC_FREC_SHIFT  3'h2

// Magnitude thresholds of a 16-bit sample
`define ALC_LVL_FS      15'h7FFF
`define ALC_LVL_M2P5    15'h5FFD
`define ALC_LVL_M4P1    15'h4FD5
`define ALC_LVL_M6P0    15'h4027
`define ALC_LVL_M8P5    15'h301B
`define ALC_LVL_M12     15'h2027

`endif

// ---- src/alc_level_ctrl.v ----
// Four-channel automatic level control with APB register access
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "alc_defines.vh"

module alc_level_ctrl (
  // Clock and reset
  input  wire        core_clk,
  input  wire        sys_rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Sample stream, one strobe per sample period
  input  wire        sample_valid,
  input  wire [15:0] pair_a_left_sample,
  input  wire [15:0] pair_a_right_sample,
  input  wire [15:0] pair_b_left_sample,
  input  wire [15:0] pair_b_right_sample,
  // Applied volume codes
  output wire [7:0]  pair_a_left_volume,
  output wire [7:0]  pair_a_right_volume,
  output wire [7:0]  pair_b_left_volume,
  output wire [7:0]  pair_b_right_volume
);

  reg  [3:0]  ctrl_r;
  reg  [31:0] cfg_a_r;
  reg  [31:0] cfg_b_r;
  reg  [15:0] vol_a_r;
  reg  [15:0] vol_b_r;
  reg         en_a_d_r;
  reg         en_b_d_r;

  wire        quad_link_en         = ctrl_r[`ALC_CT_QUAD];
  wire        pair_a_level_ctrl_en = ctrl_r[`ALC_CT_PAIR_A];
  wire        pair_b_level_ctrl_en = ctrl_r[`ALC_CT_PAIR_B];
  wire        fast_limiter_en      = ctrl_r[`ALC_CT_FAST_LIM];

  // Group enables; pair B controller idles under four-channel link
  wire        en_a = quad_link_en | pair_a_level_ctrl_en;
  wire        en_b = !quad_link_en & pair_b_level_ctrl_en;
  wire        load_a = en_a & !en_a_d_r;
  wire        load_b = en_b & !en_b_d_r;

  wire [31:0] vol_out;
  wire [63:0] samp_bus = {pair_b_right_sample, pair_b_left_sample,
                          pair_a_right_sample, pair_a_left_sample};
  wire [3:0]  ch_over;
  wire [3:0]  ch_band;
  wire [3:0]  ch_fs;
  wire [3:0]  ch_pend;

  wire [7:0]  tgt_a;
  wire [7:0]  tgt_b;
  wire        step_a;
  wire        step_b;
  wire        gate_a;
  wire        gate_b;
  wire        tmo_a;
  wire        tmo_b;

  // APB access phase takes one wait cycle; unmapped offsets answer an error
  wire        acc = psel & penable & !pready;
  // Writes land on the edge that completes the transfer, as the master sees it
  wire        wr  = psel & penable & pready & pwrite;
  wire        map_hit = (paddr == `ALC_ADDR_CTRL)  || (paddr == `ALC_ADDR_CFG_A) ||
                        (paddr == `ALC_ADDR_CFG_B) || (paddr == `ALC_ADDR_VOL_A) ||
                        (paddr == `ALC_ADDR_VOL_B) || (paddr == `ALC_ADDR_STAT);
  reg  [31:0] rd_mux;

  always @*
  begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `ALC_ADDR_CTRL:  rd_mux = {28'h0000000, ctrl_r};
      `ALC_ADDR_CFG_A: rd_mux = cfg_a_r;
      `ALC_ADDR_CFG_B: rd_mux = cfg_b_r;
      `ALC_ADDR_VOL_A: rd_mux = {16'h0000, vol_a_r};
      `ALC_ADDR_VOL_B: rd_mux = {16'h0000, vol_b_r};
      `ALC_ADDR_STAT:  rd_mux = vol_out;
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0000_0000;
      ctrl_r   <= 4'h0;
      cfg_a_r  <= `ALC_CFG_RST;
      cfg_b_r  <= `ALC_CFG_RST;
      vol_a_r  <= `ALC_VOL_RST;
      vol_b_r  <= `ALC_VOL_RST;
      en_a_d_r <= 1'b0;
      en_b_d_r <= 1'b0;
    end
    else
    begin
      pready   <= acc;
      pslverr  <= acc & !map_hit;
      prdata   <= (acc && !pwrite && map_hit) ? rd_mux : 32'h0000_0000;
      en_a_d_r <= en_a;
      en_b_d_r <= en_b;
      if (wr)
      begin
        case (paddr)
          `ALC_ADDR_CTRL:  ctrl_r  <= pwdata[3:0];
          // Unused bits are kept zero so they read back as zero
          `ALC_ADDR_CFG_A: cfg_a_r <= pwdata & 32'h00FF_3FFF;
          `ALC_ADDR_CFG_B: cfg_b_r <= pwdata & 32'h00FF_3FFF;
          `ALC_ADDR_VOL_A: vol_a_r <= pwdata[15:0];
          `ALC_ADDR_VOL_B: vol_b_r <= pwdata[15:0];
          default:         ctrl_r  <= ctrl_r;
        endcase
      end
    end
  end

  // Per-channel level detection, zero crossing and volume hold
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_ch
      wire [15:0] smp  = samp_bus[gi*16 +: 16];
      // Pair A settings serve every channel under four-channel link
      wire        use_a = quad_link_en || (gi < 2);
      wire [1:0]  thr  = use_a ? cfg_a_r[`ALC_CF_THR] : cfg_b_r[`ALC_CF_THR];
      wire [14:0] mag  = smp[15] ? ((smp == 16'h8000) ? `ALC_LVL_FS :
                                    (~smp[14:0] + 15'h0001)) : smp[14:0];
      reg  [14:0] det_lvl;
      reg  [14:0] rst_lvl;
      reg         sign_r;
      reg         pend_r;
      reg  [7:0]  vol_r;
      wire        grp_a = use_a;
      wire        en_g  = grp_a ? en_a : en_b;
      wire [7:0]  tgt   = grp_a ? tgt_a : tgt_b;
      wire        stp   = grp_a ? step_a : step_b;
      wire        gte   = grp_a ? gate_a : gate_b;
      wire        tmo   = grp_a ? tmo_a : tmo_b;
      wire [7:0]  man   = (gi == 0) ? vol_a_r[7:0] : (gi == 1) ? vol_a_r[15:8] :
                          (gi == 2) ? vol_b_r[7:0] : vol_b_r[15:8];
      wire        zc    = sample_valid && ((smp[15] != sign_r) || (smp == 16'h0000));

      always @*
      begin
        det_lvl = `ALC_LVL_M2P5;
        rst_lvl = `ALC_LVL_M4P1;
        case (thr)
          2'h0:
          begin
            det_lvl = `ALC_LVL_M2P5;
            rst_lvl = `ALC_LVL_M4P1;
          end
          2'h1:
          begin
            det_lvl = `ALC_LVL_M4P1;
            rst_lvl = `ALC_LVL_M6P0;
          end
          2'h2:
          begin
            det_lvl = `ALC_LVL_M6P0;
            rst_lvl = `ALC_LVL_M8P5;
          end
          default:
          begin
            det_lvl = `ALC_LVL_M8P5;
            rst_lvl = `ALC_LVL_M12;
          end
        endcase
      end

      assign ch_over[gi] = (mag >= det_lvl);
      assign ch_band[gi] = (mag >= rst_lvl) && (mag < det_lvl);
      assign ch_fs[gi]   = (mag >= `ALC_LVL_FS);
      assign ch_pend[gi] = pend_r;
      assign vol_out[gi*8 +: 8] = vol_r;

      always @(posedge core_clk)
      begin
        if (sys_rst)
        begin
          sign_r <= 1'b0;
          pend_r <= 1'b0;
          vol_r  <= `ALC_VOL_CH_RST;
        end
        else
        begin
          if (sample_valid)
            sign_r <= smp[15];
          if (!en_g)
          begin
            // Manual mode is not gated here: the written code applies directly
            pend_r <= 1'b0;
            vol_r  <= man;
          end
          else if (stp && !gte)
          begin
            pend_r <= 1'b0;
            vol_r  <= tgt;
          end
          else if (stp)
            pend_r <= 1'b1;
          else if (pend_r && (zc || tmo))
          begin
            pend_r <= 1'b0;
            vol_r  <= tgt;
          end
        end
      end
    end
  endgenerate

  assign pair_a_left_volume  = g_ch[0].vol_r;
  assign pair_a_right_volume = g_ch[1].vol_r;
  assign pair_b_left_volume  = g_ch[2].vol_r;
  assign pair_b_right_volume = g_ch[3].vol_r;

  // Group events: all four channels feed pair A under four-channel link
  wire ov_a = quad_link_en ? (|ch_over) : (|ch_over[1:0]);
  wire bd_a = quad_link_en ? (|ch_band) : (|ch_band[1:0]);
  wire fs_a = quad_link_en ? (|ch_fs)   : (|ch_fs[1:0]);
  wire bz_a = quad_link_en ? (|ch_pend) : (|ch_pend[1:0]);

  alc_pair_ctrl u_ctrl_a (
    .core_clk                (core_clk),
    .sys_rst                 (sys_rst),
    .sample_valid            (sample_valid),
    .over_lim                (ov_a),
    .in_band                 (bd_a),
    .over_fs                 (fs_a),
    .busy                    (bz_a),
    .enable                  (en_a),
    .load                    (load_a),
    .load_val                (vol_a_r[7:0]),
    .fast_limiter_en         (fast_limiter_en),
    .zero_cross_gate_disable (cfg_a_r[`ALC_CF_GATE_DIS]),
    .limiter_step_sel        (cfg_a_r[`ALC_CF_LSTEP]),
    .zero_cross_timeout_sel  (cfg_a_r[`ALC_CF_ZTMO]),
    .recovery_wait_sel       (cfg_a_r[`ALC_CF_WAIT]),
    .recovery_gain_step_sel  (cfg_a_r[`ALC_CF_GAIN]),
    .fast_recovery_speed_sel (cfg_a_r[`ALC_CF_FREC]),
    .recovery_ceiling        (cfg_a_r[`ALC_CF_CEIL]),
    .target_r                (tgt_a),
    .step_r                  (step_a),
    .gate_r                  (gate_a),
    .tmo_r                   (tmo_a)
  );

  alc_pair_ctrl u_ctrl_b (
    .core_clk                (core_clk),
    .sys_rst                 (sys_rst),
    .sample_valid            (sample_valid),
    .over_lim                (|ch_over[3:2]),
    .in_band                 (|ch_band[3:2]),
    .over_fs                 (|ch_fs[3:2]),
    .busy                    (|ch_pend[3:2]),
    .enable                  (en_b),
    .load                    (load_b),
    .load_val                (vol_b_r[7:0]),
    .fast_limiter_en         (fast_limiter_en),
    .zero_cross_gate_disable (cfg_b_r[`ALC_CF_GATE_DIS]),
    .limiter_step_sel        (cfg_b_r[`ALC_CF_LSTEP]),
    .zero_cross_timeout_sel  (cfg_b_r[`ALC_CF_ZTMO]),
    .recovery_wait_sel       (cfg_b_r[`ALC_CF_WAIT]),
    .recovery_gain_step_sel  (cfg_b_r[`ALC_CF_GAIN]),
    .fast_recovery_speed_sel (cfg_b_r[`ALC_CF_FREC]),
    .recovery_ceiling        (cfg_b_r[`ALC_CF_CEIL]),
    .target_r                (tgt_b),
    .step_r                  (step_b),
    .gate_r                  (gate_b),
    .tmo_r                   (tmo_b)
  );

endmodule // alc_level_ctrl

`default_nettype wire

// ---- src/alc_pair_ctrl.v ----
// Limiter and recovery controller producing one common volume target
`timescale 1ns/10ps
`default_nettype none
`include "alc_defines.vh"

module alc_pair_ctrl (
  // Clock and reset
  input  wire        core_clk,
  input  wire        sys_rst,
  // Sample events
  input  wire        sample_valid,
  input  wire        over_lim,
  input  wire        in_band,
  input  wire        over_fs,
  input  wire        busy,
  // Control
  input  wire        enable,
  input  wire        load,
  input  wire [7:0]  load_val,
  input  wire        fast_limiter_en,
  input  wire        zero_cross_gate_disable,
  input  wire [1:0]  limiter_step_sel,
  input  wire [1:0]  zero_cross_timeout_sel,
  input  wire [2:0]  recovery_wait_sel,
  input  wire [1:0]  recovery_gain_step_sel,
  input  wire [1:0]  fast_recovery_speed_sel,
  input  wire [7:0]  recovery_ceiling,
  // Volume target with its step, gate and zero-cross timeout strobes
  output reg  [7:0]  target_r,
  output reg         step_r,
  output reg         gate_r,
  output reg         tmo_r
);

  localparam ST_OFF = 1'b0;
  localparam ST_RUN = 1'b1;

  reg        state_r;
  reg        fast_r;
  reg [14:0] wait_cnt_r;
  reg [10:0] zc_cnt_r;

  wire [10:0] zc_len   = `ALC_ZTMO_BASE << zero_cross_timeout_sel;
  wire [14:0] wait_len = `ALC_WAIT_BASE << recovery_wait_sel;
  // Code 11 of the speed field is not available; it falls back to 16 times
  wire [2:0]  frec_sh  = (fast_recovery_speed_sel == 2'h3) ? 3'h4 :
                         ({1'b0, fast_recovery_speed_sel} + `ALC_FREC_SHIFT);
  wire [14:0] wait_eff = fast_r ? (wait_len >> frec_sh) : wait_len;
  wire [7:0]  lim_amt  = zero_cross_gate_disable ? `ALC_VOL_ONE :
                         (`ALC_VOL_ONE << limiter_step_sel);
  wire [7:0]  gain_amt = {6'h00, recovery_gain_step_sel} + `ALC_VOL_ONE;
  wire [8:0]  up_sum   = {1'b0, target_r} + {1'b0, gain_amt};
  wire [7:0]  up_val   = (up_sum > {1'b0, recovery_ceiling}) ?
                         recovery_ceiling : up_sum[7:0];
  wire [7:0]  dn_val   = (target_r > lim_amt) ? (target_r - lim_amt) :
                         `ALC_VOL_MUTE;
  wire [7:0]  dn_one   = (target_r > `ALC_VOL_ONE) ? (target_r - `ALC_VOL_ONE) :
                         `ALC_VOL_MUTE;

  // Zero-cross timeout runs while any channel of the group waits
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      zc_cnt_r <= 11'h000;
      tmo_r    <= 1'b0;
    end
    else
    begin
      tmo_r <= 1'b0;
      if (step_r || !busy)
        zc_cnt_r <= 11'h000;
      else if (sample_valid)
      begin
        if (zc_cnt_r + 11'h001 >= zc_len)
        begin
          zc_cnt_r <= 11'h000;
          tmo_r    <= 1'b1;
        end
        else
          zc_cnt_r <= zc_cnt_r + 11'h001;
      end
    end
  end

  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_r    <= ST_OFF;
      target_r   <= `ALC_VOL_MUTE;
      step_r     <= 1'b0;
      gate_r     <= 1'b0;
      fast_r     <= 1'b0;
      wait_cnt_r <= 15'h0000;
    end
    else
    begin
      step_r <= 1'b0;
      case (state_r)
        ST_OFF:
        begin
          fast_r     <= 1'b0;
          wait_cnt_r <= 15'h0000;
          if (enable && load)
          begin
            target_r <= load_val;
            state_r  <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          if (!enable)
            state_r <= ST_OFF;
          else if (sample_valid)
          begin
            if (over_fs && fast_limiter_en)
            begin
              // Full scale is an impulse: one step at once, no gating
              target_r   <= dn_one;
              step_r     <= 1'b1;
              gate_r     <= 1'b0;
              fast_r     <= 1'b1;
              wait_cnt_r <= 15'h0000;
            end
            else if (over_lim)
            begin
              wait_cnt_r <= 15'h0000;
              if (!busy)
              begin
                target_r <= dn_val;
                step_r   <= 1'b1;
                gate_r   <= !zero_cross_gate_disable;
                fast_r   <= over_fs;
              end
            end
            else if (in_band)
              wait_cnt_r <= 15'h0000;
            else if (wait_cnt_r + 15'h0001 >= wait_eff)
            begin
              // Held at the end while a step is still pending
              if (!busy)
              begin
                wait_cnt_r <= 15'h0000;
                if (target_r < recovery_ceiling)
                begin
                  target_r <= up_val;
                  step_r   <= 1'b1;
                  gate_r   <= 1'b1;
                end
                else
                  fast_r <= 1'b0;
              end
            end
            else
              wait_cnt_r <= wait_cnt_r + 15'h0001;
          end
        end
        default:
          state_r <= ST_OFF;
      endcase
    end
  end

endmodule // alc_pair_ctrl

`default_nettype wire

// ---- verif/alc_adc_src.sv ----
// Stand-in for the four converter sample paths
`timescale 1ns/10ps
`default_nettype none
module alc_adc_src #(
  parameter int PER = 16
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Level of the next sample, pair A left in the low half-word
  input  wire logic [63:0] level_in,
  // Sample stream
  output var  logic        sample_valid,
  output wire logic [15:0] pair_a_left_sample,
  output wire logic [15:0] pair_a_right_sample,
  output wire logic [15:0] pair_b_left_sample,
  output wire logic [15:0] pair_b_right_sample
);
  int          cnt;
  logic [63:0] smp_r;
  assign {pair_b_right_sample, pair_b_left_sample} = smp_r[63:32];
  assign {pair_a_right_sample, pair_a_left_sample} = smp_r[31:0];
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cnt <= 0;
      sample_valid <= 1'b0;
      smp_r <= 64'h0;
    end
    else if (cnt == PER - 1)
    begin
      cnt <= 0;
      sample_valid <= 1'b1;
      smp_r <= level_in;
    end
    else
    begin
      cnt <= cnt + 1;
      sample_valid <= 1'b0;
      // Off the strobe the lines toggle, so a capture at a wrong edge shows up
      smp_r <= ~smp_r;
    end
  end
endmodule // alc_adc_src
`default_nettype wire

// ---- verif/alc_level_ctrl_chk.sv ----
// Port-level assertions for the level control block
`timescale 1ns/10ps
`default_nettype none
module alc_level_ctrl_chk (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        sys_rst,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Applied volumes
  input wire logic [7:0]  pair_a_left_volume,
  input wire logic [7:0]  pair_a_right_volume,
  input wire logic [7:0]  pair_b_left_volume,
  input wire logic [7:0]  pair_b_right_volume
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // Shadows of written settings, since the block's copies are not visible here
  logic [2:0]  ctl_r;
  logic        gd_r;
  logic [15:0] va_r;
  wire         wr = psel && penable && pready && pwrite;
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      ctl_r <= 3'h0;
      gd_r  <= 1'b0;
      va_r  <= 16'h9191;
    end
    else if (wr)
    begin
      if (paddr == 8'h00)
        ctl_r <= pwdata[2:0];
      if (paddr == 8'h04)
        gd_r <= pwdata[2];
      if (paddr == 8'h0C)
        va_r <= pwdata[15:0];
    end
  end
  wire bad = paddr > 8'h14 || paddr[1:0] != 2'h0;
  wire lnk = ctl_r[0] && !ctl_r[2] && gd_r;
  wire man = !ctl_r[0] && !ctl_r[2];
  sequence apb_req;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence a_drop;
    lnk && $past(lnk) && pair_a_left_volume < $past(pair_a_left_volume);
  endsequence
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  access_len_a: assert property (apb_req |=> pready)
    else $error("access phase not two cycles");
  bad_addr_a: assert property (apb_req ##0 bad |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  good_addr_a: assert property (apb_req ##0 !bad |=> !pslverr)
    else $error("mapped access refused");
  idle_rdata_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data or error outside access");
  reset_vol_a: assert property ($past(sys_rst) |-> {pair_b_right_volume, pair_b_left_volume,
    pair_a_right_volume, pair_a_left_volume} == 32'h9191_9191)
    else $error("volumes not at reset code");
  manual_vol_a: assert property (man && $past(man) && $past(man, 2) && $stable(va_r) &&
    $past(va_r, 2) == va_r |-> {pair_a_right_volume, pair_a_left_volume} == va_r)
    else $error("manual volume differs from written code");
  link_step_a: assert property (a_drop |-> pair_a_right_volume == pair_a_left_volume &&
    pair_a_left_volume == $past(pair_a_left_volume) - 8'h01)
    else $error("ungated linked step not single and common");
  quad_common_a: assert property (ctl_r[2] && gd_r && $past(ctl_r[2]) &&
    pair_b_left_volume < $past(pair_b_left_volume) |-> pair_a_left_volume == pair_b_left_volume
    && pair_a_right_volume == pair_b_left_volume && pair_b_right_volume == pair_b_left_volume)
    else $error("four linked volumes differ after a cut");
endmodule // alc_level_ctrl_chk
bind alc_level_ctrl alc_level_ctrl_chk u_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .pair_a_left_volume(pair_a_left_volume), .pair_a_right_volume(pair_a_right_volume),
  .pair_b_left_volume(pair_b_left_volume), .pair_b_right_volume(pair_b_right_volume)
);
`default_nettype wire

// ---- verif/tb_auto_level_control.sv ----
// Self-checking bench for the automatic level control block
`timescale 1ns/10ps
`default_nettype none
module tb_auto_level_control;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, r;
  logic        pready, pslverr, perr, sample_valid;
  logic        sgn = 1'b0;
  logic [15:0] a_l_s, a_r_s, b_l_s, b_r_s;
  logic [7:0]  a_l_v, a_r_v, b_l_v, b_r_v;
  logic [63:0] level = 64'h0;
  logic [7:0]  ev [4];
  logic [31:0] regv [7] = '{32'h0, 32'h00E1_0000, 32'h00E1_0000, 32'h9191, 32'h9191,
                            32'h9191_9191, 32'h0};
  int          num_errors = 0;
  int          checks_done = 0;
  int          i;
  integer      seed = 32'hD20F;
  always #12.5 core_clk = ~core_clk;
  alc_level_ctrl u_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
    .pair_a_left_sample(a_l_s), .pair_a_right_sample(a_r_s),
    .pair_b_left_sample(b_l_s), .pair_b_right_sample(b_r_s),
    .pair_a_left_volume(a_l_v), .pair_a_right_volume(a_r_v),
    .pair_b_left_volume(b_l_v), .pair_b_right_volume(b_r_v)
  );
  alc_adc_src u_src (
    .core_clk(core_clk), .sys_rst(sys_rst), .level_in(level), .sample_valid(sample_valid),
    .pair_a_left_sample(a_l_s), .pair_a_right_sample(a_r_s),
    .pair_b_left_sample(b_l_s), .pair_b_right_sample(b_r_s)
  );
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Entered right after a rising edge; leaves one idle cycle behind it
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    begin
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do
      begin
        @(posedge core_clk);
        n++;
      end
      while (pready !== 1'b1 && n < 40);
      q = prdata;
      perr = pslverr;
      if (n >= 40)
        num_errors++;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  task automatic feed(input logic [15:0] al, ar, bl, br, input int n);
    level <= {br, bl, ar, al};
    @(posedge core_clk);
    repeat (n)
    begin
      @(posedge core_clk);
      while (sample_valid !== 1'b1)
        @(posedge core_clk);
    end
    repeat (3) @(posedge core_clk);
  endtask
  // Quiet samples of random size that cross zero every time
  task automatic quiet(input int n);
    logic [15:0] s;
    repeat (n)
    begin
      s = 16'($random(seed)) & 16'h0FFF | 16'h0001;
      sgn = ~sgn;
      if (sgn)
        s = -s;
      feed(s, s, s, s, 1);
    end
  endtask
  task automatic lim(input logic [3:0] m, input int n);
    for (int c = 0; c < 4; c++)
      if (m[c])
        ev[c] = (ev[c] > n) ? ev[c] - 8'(n) : 8'h00;
  endtask
  task automatic chk_vols;
    logic [31:0] q;
    begin
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      chk({b_r_v, b_l_v, a_r_v, a_l_v}, {ev[3], ev[2], ev[1], ev[0]});
      @(posedge core_clk);
      apb(1'b0, 8'h14, 32'h0, q);
      chk(q, {ev[3], ev[2], ev[1], ev[0]});
    end
  endtask
  task automatic off;
    logic [31:0] q;
    begin
      apb(1'b1, 8'h00, 32'h0, q);
      feed(16'h0100, 16'h0100, 16'h0100, 16'h0100, 1);
      ev = '{8'h91, 8'h91, 8'h91, 8'h91};
      chk_vols;
    end
  endtask
  initial
  begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    for (i = 0; i < 7; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0, rd);
      chk(rd, regv[i]);
      chk({31'h0, perr}, {31'h0, i == 6});
    end
    apb(1'b1, 8'h14, 32'h0, rd);
    apb(1'b1, 8'h18, 32'hFFFF_FFFF, rd);
    ev = '{8'h91, 8'h91, 8'h91, 8'h91};
    chk_vols;
    for (i = 0; i < 3; i++)
    begin
      r = $random(seed);
      apb(1'b1, 8'h0C, {16'h0, r[15:0]}, rd);
      apb(1'b1, 8'h10, {16'h0, r[31:16]}, rd);
      ev = '{r[7:0], r[15:8], r[23:16], r[31:24]};
      chk_vols;
    end
    apb(1'b1, 8'h0C, 32'h9191, rd);
    apb(1'b1, 8'h10, 32'h9191, rd);
    // Gate off with an eight-step code: each cut must still be one step
    apb(1'b1, 8'h04, 32'h00E1_001C, rd);
    off;
    apb(1'b1, 8'h00, 32'h1, rd);
    feed(16'h6000, 16'h0100, 16'h0100, 16'h0100, 2);
    lim(4'h3, 2);
    chk_vols;
    feed(16'h0100, 16'h6000, 16'h6000, 16'h0100, 1);
    lim(4'h3, 1);
    chk_vols;
    off;
    // Pair B asks for gating and must be ignored under the four-channel link
    apb(1'b1, 8'h08, 32'h00E1_0018, rd);
    apb(1'b1, 8'h00, 32'h4, rd);
    feed(16'h0100, 16'h0100, 16'h0100, 16'h6000, 1);
    lim(4'hF, 1);
    chk_vols;
    off;
    apb(1'b1, 8'h04, 32'h00E1_0010, rd);
    apb(1'b1, 8'h00, 32'h1, rd);
    feed(16'h6000, 16'h0010, 16'h0100, 16'h0100, 1);
    chk_vols;
    feed(16'hFFF0, 16'h0010, 16'h0100, 16'h0100, 1);
    lim(4'h1, 4);
    chk_vols;
    feed(16'hFFF0, 16'hFFF0, 16'h0100, 16'h0100, 1);
    lim(4'h2, 4);
    chk_vols;
    off;
    for (i = 0; i < 2; i++)
    begin
      apb(1'b1, 8'h04, 32'h00E1_0000 + 32'(i) * 32'h20, rd);
      apb(1'b1, 8'h00, 32'h1, rd);
      feed(16'h6000, 16'h0100, 16'h0100, 16'h0100, 1);
      feed(16'h0100, 16'h0100, 16'h0100, 16'h0100, (128 << i) - 8);
      chk_vols;
      feed(16'h0100, 16'h0100, 16'h0100, 16'h0100, 16);
      lim(4'h3, 1);
      chk_vols;
      off;
    end
    // Ceiling one code above the start: a four-step gain must stop there
    apb(1'b1, 8'h04, 32'h0092_0C04, rd);
    apb(1'b1, 8'h00, 32'h1, rd);
    feed(16'h6000, 16'h0100, 16'h0100, 16'h0100, 2);
    lim(4'h3, 2);
    quiet(100);
    feed(16'h5000, 16'h5000, 16'h0100, 16'h0100, 1);
    quiet(100);
    chk_vols;
    quiet(60);
    ev[0] = 8'h92;
    ev[1] = 8'h92;
    chk_vols;
    off;
    // Lowest threshold: just above it cuts, with a positive and then a negative sample
    apb(1'b1, 8'h04, 32'h00E1_0007, rd);
    apb(1'b1, 8'h00, 32'h1, rd);
    feed(16'h3100, 16'h2F00, 16'h0100, 16'h0100, 1);
    lim(4'h3, 1);
    chk_vols;
    feed(16'h2F00, 16'hCF00, 16'h0100, 16'h0100, 1);
    lim(4'h3, 1);
    chk_vols;
    off;
    apb(1'b1, 8'h04, 32'h00E1_0000, rd);
    apb(1'b1, 8'h00, 32'h9, rd);
    feed(16'h7FFF, 16'h0100, 16'h0100, 16'h0100, 1);
    lim(4'h3, 1);
    chk_vols;
    off;
    tally_and_finish;
  end
  initial
  begin
    #1_000_000;
    num_errors++;
    tally_and_finish;
  end
endmodule // tb_auto_level_control
`default_nettype wire
